// *** hdl/tsc_dev.sv ***
// Codec front end: slot timing, monitor handshake, command interpreter
//
// Notes on behaviour
// - Timing from highway clock and frame sync
// - Frame holds eight channels, numbered 0 to 7
// - Two tri-level straps select the channel
// - Channel: voice, voice, monitor, C/I plus handshake
// - Commands need own address byte first
// - Identify request answered with two ID bytes
// - Old revision ignores the next three write commands after a write; a read ends this
// - Controller follows each write with a read; the bench sends a second write before its read
// - Status read returns first config register
// - Newer revision accepts commands right after write
//
// Local design decisions: the register addresses and the plain strobed port.
`default_nettype none
module tsc_dev #(
  parameter logic [7:0] DEV_ADDR = 8'hc5, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5a3c, // Arbitrary value
  parameter bit LEGACY_REV = 1'h1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  tsc_hwy_if.dev hwy,
  input wire logic [1:0] slot_strap_a_i,
  input wire logic [1:0] slot_strap_b_i,
  input wire logic [15:0] voice_tx_i,
  input wire logic [5:0] ci_tx_i,
  output logic [15:0] voice_rx_o,
  output logic [5:0] ci_rx_o,
  output logic [7:0] first_config_register_o,
  output logic [2:0] slot_o
);
  typedef enum logic [1:0] {CI_IDLE, CI_ID2, CI_CMD, CI_DATA} tsc_cmd_t;

  if (DEV_ADDR == tsc_pkg::ID_REQ0)
    $error("Device address must differ from the identify request");

  logic [6:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic clkd_ff, nxt_clkd;
  logic [8:0] edge_ff, nxt_edge, cur_edge;
  logic [2:0] slot_ff, nxt_slot;
  logic rise, in_slot, drv, smp, last;
  logic [4:0] pos;
  logic up_ff, nxt_up, up_oe_ff, nxt_up_oe;
  logic [31:0] txsh_ff, nxt_txsh, rxsh_ff, nxt_rxsh, word, tw;
  logic [15:0] voice_ff, nxt_voice;
  logic [5:0] ci_ff, nxt_ci;
  logic monitor_receive_ack_ff, nxt_monitor_receive_ack;
  logic monitor_transmit_valid_ff, nxt_monitor_transmit_valid;
  logic [7:0] mon_tx_ff, nxt_mon_tx;
  tsc_pkg::tsc_hs_t hs_ff, nxt_hs;
  logic push, take, pop, fifo_rdy, fifo_vld;
  logic [7:0] mem_ff [2];
  logic [7:0] nxt_mem [2];
  logic wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [1:0] fill_ff, nxt_fill;
  logic [7:0] head;
  tsc_cmd_t st_ff, nxt_st;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [1:0] blk_ff, nxt_blk;
  logic [3:0] left_ff, nxt_left;
  logic stat_ff, nxt_stat, ign_ff, nxt_ign;
  logic [15:0] rep_ff, nxt_rep;
  logic [1:0] rcnt_ff, nxt_rcnt;

  // Edge and position decode; rising edges are counted since frame sync
  assign rise = sync2_ff[6] & ~clkd_ff;
  assign cur_edge = sync2_ff[5] ? 9'h000 : 9'(edge_ff + 9'h001);
  // Compare against the slot being taken now, so the old one is not
  // driven for a single bit at the frame start when the straps change
  assign in_slot = (cur_edge[8:6] == nxt_slot);
  assign pos = cur_edge[5:1];
  assign drv = rise & ~cur_edge[0];
  assign smp = rise & cur_edge[0] & in_slot;
  assign last = smp & (pos == 5'h1f);
  assign word = {rxsh_ff[30:0], sync2_ff[4]};
  assign tw = tsc_pkg::pack_slot(voice_tx_i, mon_tx_ff, ci_tx_i,
    monitor_receive_ack_ff, monitor_transmit_valid_ff);

  // Pin synchronisers, edge counter and strap capture at frame start
  always_comb
  begin
    nxt_sync1 = {hwy.highway_bit_clock, hwy.fsync, hwy.dn_data,
                 slot_strap_a_i, slot_strap_b_i};
    nxt_sync2 = sync1_ff;
    nxt_clkd = sync2_ff[6];
    nxt_edge = edge_ff;
    nxt_slot = slot_ff;
    if (rise)
    begin
      nxt_edge = cur_edge;
      if (sync2_ff[5])
        nxt_slot = tsc_pkg::strap_to_ch(sync2_ff[3:2], sync2_ff[1:0]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
      clkd_ff <= 1'h0;
      // First rise after reset is the controller's last period, not slot 0
      edge_ff <= 9'(tsc_pkg::PER_LAST - 9'h001);
      slot_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      clkd_ff <= nxt_clkd;
      edge_ff <= nxt_edge;
      slot_ff <= nxt_slot;
    end
  end

  // Slot shifters, stepped each bit, and the monitor handshake, evaluated once per frame
  always_comb
  begin
    nxt_up = up_ff;
    nxt_up_oe = up_oe_ff;
    nxt_txsh = txsh_ff;
    nxt_rxsh = rxsh_ff;
    nxt_voice = voice_ff;
    nxt_ci = ci_ff;
    nxt_monitor_receive_ack = monitor_receive_ack_ff;
    nxt_monitor_transmit_valid = monitor_transmit_valid_ff;
    nxt_mon_tx = mon_tx_ff;
    nxt_hs = hs_ff;
    push = 1'h0;
    take = 1'h0;
    if (drv)
    begin
      nxt_up_oe = in_slot; // Release the line outside our channel
      nxt_up = 1'h1;
      if (in_slot && pos == 5'h00)
      begin
        nxt_up = tw[31];
        nxt_txsh = {tw[30:0], 1'h0};
      end
      else if (in_slot)
      begin
        nxt_up = txsh_ff[31];
        nxt_txsh = {txsh_ff[30:0], 1'h0};
      end
    end
    if (smp)
      nxt_rxsh = word;
    if (last)
    begin
      nxt_voice = word[31:16];
      nxt_ci = word[7:2];
      // A full buffer withholds the ack, so the byte is offered again
      if (!word[0])
        nxt_monitor_receive_ack = 1'h0;
      else if (!monitor_receive_ack_ff && fifo_rdy)
      begin
        push = 1'h1;
        nxt_monitor_receive_ack = 1'h1;
      end
      case (hs_ff)
        tsc_pkg::HS_IDLE:
          if (rcnt_ff != 2'h0)
          begin
            nxt_mon_tx = rep_ff[15:8];
            nxt_monitor_transmit_valid = 1'h1;
            take = 1'h1;
            nxt_hs = tsc_pkg::HS_WAIT;
          end
        tsc_pkg::HS_WAIT:
          if (word[1])
          begin
            nxt_monitor_transmit_valid = 1'h0;
            nxt_hs = tsc_pkg::HS_GAP;
          end
        tsc_pkg::HS_GAP:
          if (!word[1])
            nxt_hs = tsc_pkg::HS_IDLE;
        default: nxt_hs = tsc_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      up_ff <= 1'h1;
      up_oe_ff <= 1'h0;
      txsh_ff <= 32'h0;
      rxsh_ff <= 32'h0;
      voice_ff <= 16'h0;
      ci_ff <= 6'h0;
      monitor_receive_ack_ff <= 1'h0;
      monitor_transmit_valid_ff <= 1'h0;
      mon_tx_ff <= 8'h00;
      hs_ff <= tsc_pkg::HS_IDLE;
    end
    else
    begin
      up_ff <= nxt_up;
      up_oe_ff <= nxt_up_oe;
      txsh_ff <= nxt_txsh;
      rxsh_ff <= nxt_rxsh;
      voice_ff <= nxt_voice;
      ci_ff <= nxt_ci;
      monitor_receive_ack_ff <= nxt_monitor_receive_ack;
      monitor_transmit_valid_ff <= nxt_monitor_transmit_valid;
      mon_tx_ff <= nxt_mon_tx;
      hs_ff <= nxt_hs;
    end
  end

  // Two-entry buffer between monitor receiver and interpreter
  assign fifo_rdy = (fill_ff != 2'h2);
  assign fifo_vld = (fill_ff != 2'h0);
  assign head = mem_ff[rp_ff];
  assign pop = fifo_vld && (rcnt_ff == 2'h0); // Stall while replying
  always_comb
  begin
    nxt_mem = mem_ff;
    if (push)
      nxt_mem[wp_ff] = word[15:8];
    nxt_wp = wp_ff ^ push;
    nxt_rp = rp_ff ^ pop;
    nxt_fill = 2'(fill_ff + {1'h0, push} - {1'h0, pop});
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mem_ff[0] <= 8'h00;
      mem_ff[1] <= 8'h00;
      wp_ff <= 1'h0;
      rp_ff <= 1'h0;
      fill_ff <= 2'h0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      fill_ff <= nxt_fill;
    end
  end

  // Command interpreter: address, identify, status and coefficient access
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cfg = cfg_ff;
    nxt_blk = blk_ff;
    nxt_left = left_ff;
    nxt_stat = stat_ff;
    nxt_ign = ign_ff;
    nxt_rep = rep_ff;
    nxt_rcnt = rcnt_ff;
    if (take)
    begin
      nxt_rep = {rep_ff[7:0], 8'h00};
      nxt_rcnt = 2'(rcnt_ff - 2'h1);
    end
    if (pop)
    begin
      case (st_ff)
        CI_IDLE:
          if (head == tsc_pkg::ID_REQ0)
            nxt_st = CI_ID2;
          else if (head == DEV_ADDR)
            nxt_st = CI_CMD;
        CI_ID2:
        begin
          nxt_st = CI_IDLE;
          if (head == tsc_pkg::ID_REQ1)
          begin
            nxt_rep = DEV_ID;
            nxt_rcnt = 2'h2;
          end
        end
        CI_CMD:
          if (head[tsc_pkg::CMD_READ_BIT])
          begin
            nxt_rep = {DEV_ADDR, cfg_ff};
            nxt_rcnt = 2'h2;
            nxt_blk = 2'h0;
            nxt_st = CI_IDLE;
          end
          else
          begin
            // Blocked writes still swallow their data bytes
            nxt_ign = (blk_ff != 2'h0);
            if (blk_ff != 2'h0)
              nxt_blk = 2'(blk_ff - 2'h1);
            nxt_stat = ~head[tsc_pkg::CMD_COEF_BIT];
            nxt_left = head[tsc_pkg::CMD_COEF_BIT] ? tsc_pkg::COEF_LEN
                                                  : tsc_pkg::STAT_LEN;
            nxt_st = CI_DATA;
          end
        CI_DATA:
        begin
          // Filter coefficients are not modelled and are discarded
          if (stat_ff && !ign_ff)
            nxt_cfg = head;
          nxt_left = 4'(left_ff - 4'h1);
          if (left_ff == 4'h1)
          begin
            nxt_st = CI_IDLE;
            if (!ign_ff && LEGACY_REV)
              nxt_blk = tsc_pkg::BLOCK_CNT;
          end
        end
        default: nxt_st = CI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff <= CI_IDLE;
      cfg_ff <= tsc_pkg::CFG_RST;
      blk_ff <= 2'h0;
      left_ff <= 4'h0;
      stat_ff <= 1'h0;
      ign_ff <= 1'h0;
      rep_ff <= 16'h0;
      rcnt_ff <= 2'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cfg_ff <= nxt_cfg;
      blk_ff <= nxt_blk;
      left_ff <= nxt_left;
      stat_ff <= nxt_stat;
      ign_ff <= nxt_ign;
      rep_ff <= nxt_rep;
      rcnt_ff <= nxt_rcnt;
    end
  end

  assign hwy.up_dev = up_ff;
  assign hwy.up_dev_oe = up_oe_ff;
  assign voice_rx_o = voice_ff;
  assign ci_rx_o = ci_ff;
  assign first_config_register_o = cfg_ff;
  assign slot_o = slot_ff;
endmodule
`default_nettype wire

// *** common/tsc_pkg.sv ***
// Shared constants, types and helpers for the slot command port
`default_nettype none
package tsc_pkg;
  // Clock rates and the frame time
  localparam int SYS_HZ = 40_000_000;
  localparam int HWY_HZ = 4_096_000;
  localparam int FRAME_HZ = 8_000;
  localparam int FRAME_US = 125;
  // Half period of the generated highway clock in system cycles
  localparam int HALF_RAW = SYS_HZ / (2 * HWY_HZ);
  localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;
  // Highway clock periods per frame, two periods carry one bit
  localparam int FRAME_PER = HWY_HZ / FRAME_HZ;
  localparam logic [8:0] PER_LAST = 9'(FRAME_PER - 1);
  localparam int CH_NUM = 8;
  localparam int SLOT_BITS = 32;
  // Tri-level strap codes as delivered by the level translator
  localparam logic [1:0] STRAP_ZERO = 2'h0;
  localparam logic [1:0] STRAP_P = 2'h1;
  localparam logic [1:0] STRAP_N = 2'h2;
  // Monitor channel protocol bytes and counts
  localparam logic [7:0] ID_REQ0 = 8'h80;
  localparam logic [7:0] ID_REQ1 = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] BLOCK_CNT = 2'h3;
  localparam logic [3:0] COEF_LEN = 4'h8;
  localparam logic [3:0] STAT_LEN = 4'h1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_COEF_BIT = 3;
  // Controller register map
  localparam logic [1:0] REG_TX = 2'h0;
  localparam logic [1:0] REG_RX = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_CHAN = 2'h3;
  localparam int STAT_RXV = 0;
  localparam int STAT_BUSY = 1;
  localparam logic [2:0] CHAN_RST = 3'h0;

  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_GAP} tsc_hs_t;

  // Strap pair to channel number; unlisted pairs fall back to channel 0
  function automatic logic [2:0] strap_to_ch(input logic [1:0] a,
                                             input logic [1:0] b);
    logic [2:0] ch;
    ch = 3'h0;
    case ({a, b})
      {STRAP_ZERO, STRAP_N}: ch = 3'h1;
      {STRAP_P, STRAP_ZERO}: ch = 3'h2;
      {STRAP_P, STRAP_N}: ch = 3'h3;
      {STRAP_ZERO, STRAP_P}: ch = 3'h4;
      {STRAP_N, STRAP_ZERO}: ch = 3'h5;
      {STRAP_P, STRAP_P}: ch = 3'h6;
      {STRAP_N, STRAP_P}: ch = 3'h7;
      default: ch = 3'h0;
    endcase
    return ch;
  endfunction

  // One channel: two voice bytes, monitor byte, C/I, ack, valid
  function automatic logic [31:0] pack_slot(input logic [15:0] voice,
    input logic [7:0] mon, input logic [5:0] ci, input logic ack,
    input logic vld);
    return {voice, mon, ci, ack, vld};
  endfunction
endpackage
`default_nettype wire

// *** common/tsc_hwy_if.sv ***
// Serial highway between line-card controller and codec front end
`default_nettype none
interface tsc_hwy_if;
  logic highway_bit_clock;
  logic fsync;
  logic dn_data;
  logic up_dev;
  logic up_dev_oe;
  logic up_data;
  // Upstream line is open drain with a pull-up
  assign up_data = up_dev_oe ? up_dev : 1'h1;
  modport dev (input highway_bit_clock, input fsync, input dn_data,
               input up_data, output up_dev, output up_dev_oe);
  modport ctl (output highway_bit_clock, output fsync, output dn_data,
               input up_data);
endinterface
`default_nettype wire

// *** hdl/tsc_ctl.sv ***
// Line-card controller end: highway timing and monitor byte transfer
`default_nettype none
module tsc_ctl (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  tsc_hwy_if.ctl hwy,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  logic [7:0] div_ff, nxt_div;
  logic bclk_ff, nxt_bclk, fs_ff, nxt_fs, dd_ff, nxt_dd;
  logic [8:0] per_ff, nxt_per;
  logic up1_ff, up2_ff;
  logic fall, in_slot, load, smp, last;
  logic [4:0] pos;
  logic [31:0] txsh_ff, nxt_txsh, rxsh_ff, nxt_rxsh, word, tw;
  logic [2:0] chan_ff, nxt_chan;
  logic [7:0] txb_ff, nxt_txb, rxb_ff, nxt_rxb, rdata_ff, nxt_rdata;
  logic txpend_ff, nxt_txpend, rxv_ff, nxt_rxv;
  logic monitor_receive_ack_ff, nxt_monitor_receive_ack;
  logic monitor_transmit_valid_ff, nxt_monitor_transmit_valid;
  tsc_pkg::tsc_hs_t hs_ff, nxt_hs;
  logic busy;

  // The falling toggle ends one clock period and starts the next
  assign fall = bclk_ff && (div_ff == 8'(tsc_pkg::HALF_CYC - 1));
  assign nxt_per = fall ? 9'(per_ff + 9'h001) : per_ff;
  assign in_slot = (nxt_per[8:6] == chan_ff);
  assign pos = nxt_per[5:1];
  assign load = fall & ~nxt_per[0];
  assign smp = fall & per_ff[0] & (per_ff[8:6] == chan_ff);
  assign last = smp & (per_ff[5:1] == 5'h1f);
  assign word = {rxsh_ff[30:0], up2_ff};
  assign tw = tsc_pkg::pack_slot(16'h0000, txb_ff, 6'h3f,
    monitor_receive_ack_ff, monitor_transmit_valid_ff);
  assign busy = txpend_ff | (hs_ff != tsc_pkg::HS_IDLE);

  // Clock divider, frame sync and downstream shifter
  always_comb
  begin
    nxt_div = 8'(div_ff + 8'h01);
    nxt_bclk = bclk_ff;
    nxt_fs = fs_ff;
    nxt_dd = dd_ff;
    nxt_txsh = txsh_ff;
    nxt_rxsh = rxsh_ff;
    if (div_ff == 8'(tsc_pkg::HALF_CYC - 1))
    begin
      nxt_div = 8'h00;
      nxt_bclk = ~bclk_ff;
    end
    if (fall)
      nxt_fs = (nxt_per == 9'h000);
    if (load)
    begin
      nxt_dd = 1'h1;
      if (in_slot && pos == 5'h00)
      begin
        nxt_dd = tw[31];
        nxt_txsh = {tw[30:0], 1'h0};
      end
      else if (in_slot)
      begin
        nxt_dd = txsh_ff[31];
        nxt_txsh = {txsh_ff[30:0], 1'h0};
      end
    end
    if (smp)
      nxt_rxsh = word;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_ff <= 8'h00;
      bclk_ff <= 1'h0;
      per_ff <= tsc_pkg::PER_LAST;
      fs_ff <= 1'h0;
      dd_ff <= 1'h1;
      txsh_ff <= 32'h0;
      rxsh_ff <= 32'h0;
      up1_ff <= 1'h1;
      up2_ff <= 1'h1;
    end
    else
    begin
      div_ff <= nxt_div;
      bclk_ff <= nxt_bclk;
      per_ff <= nxt_per;
      fs_ff <= nxt_fs;
      dd_ff <= nxt_dd;
      txsh_ff <= nxt_txsh;
      rxsh_ff <= nxt_rxsh;
      up1_ff <= hwy.up_data;
      up2_ff <= up1_ff;
    end
  end

  // Register port and monitor handshake; writes to TX while busy are dropped
  always_comb
  begin
    nxt_chan = chan_ff;
    nxt_txb = txb_ff;
    nxt_txpend = txpend_ff;
    nxt_rxb = rxb_ff;
    nxt_rxv = rxv_ff;
    nxt_rdata = 8'h00;
    nxt_monitor_receive_ack = monitor_receive_ack_ff;
    nxt_monitor_transmit_valid = monitor_transmit_valid_ff;
    nxt_hs = hs_ff;
    if (wr_i && addr_i == tsc_pkg::REG_TX && !busy)
    begin
      nxt_txb = wdata_i;
      nxt_txpend = 1'h1;
    end
    if (wr_i && addr_i == tsc_pkg::REG_CHAN)
      nxt_chan = wdata_i[2:0];
    if (rd_i)
    begin
      case (addr_i)
        tsc_pkg::REG_TX: nxt_rdata = txb_ff;
        tsc_pkg::REG_RX: nxt_rdata = rxb_ff;
        tsc_pkg::REG_STAT: nxt_rdata = {6'h00, busy, rxv_ff};
        tsc_pkg::REG_CHAN: nxt_rdata = {5'h00, chan_ff};
        default: nxt_rdata = 8'h00;
      endcase
      if (addr_i == tsc_pkg::REG_RX)
        nxt_rxv = 1'h0;
    end
    if (last)
    begin
      // An unread byte withholds the ack until software takes it
      if (!word[0])
        nxt_monitor_receive_ack = 1'h0;
      else if (!monitor_receive_ack_ff && !rxv_ff)
      begin
        nxt_rxb = word[15:8];
        nxt_rxv = 1'h1;
        nxt_monitor_receive_ack = 1'h1;
      end
      case (hs_ff)
        tsc_pkg::HS_IDLE:
          if (txpend_ff)
          begin
            nxt_txpend = 1'h0;
            nxt_monitor_transmit_valid = 1'h1;
            nxt_hs = tsc_pkg::HS_WAIT;
          end
        tsc_pkg::HS_WAIT:
          if (word[1])
          begin
            nxt_monitor_transmit_valid = 1'h0;
            nxt_hs = tsc_pkg::HS_GAP;
          end
        tsc_pkg::HS_GAP:
          if (!word[1])
            nxt_hs = tsc_pkg::HS_IDLE;
        default: nxt_hs = tsc_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      chan_ff <= tsc_pkg::CHAN_RST;
      txb_ff <= 8'h00;
      txpend_ff <= 1'h0;
      rxb_ff <= 8'h00;
      rxv_ff <= 1'h0;
      rdata_ff <= 8'h00;
      monitor_receive_ack_ff <= 1'h0;
      monitor_transmit_valid_ff <= 1'h0;
      hs_ff <= tsc_pkg::HS_IDLE;
    end
    else
    begin
      chan_ff <= nxt_chan;
      txb_ff <= nxt_txb;
      txpend_ff <= nxt_txpend;
      rxb_ff <= nxt_rxb;
      rxv_ff <= nxt_rxv;
      rdata_ff <= nxt_rdata;
      monitor_receive_ack_ff <= nxt_monitor_receive_ack;
      monitor_transmit_valid_ff <= nxt_monitor_transmit_valid;
      hs_ff <= nxt_hs;
    end
  end

  assign hwy.highway_bit_clock = bclk_ff;
  assign hwy.fsync = fs_ff;
  assign hwy.dn_data = dd_ff;
  assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// *** test/tsc_hwy_assertions.sv ***
// Timing assertions on the serial highway between the two ends
`default_nettype none
module tsc_hwy_assertions (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic highway_bit_clock,
  input wire logic fsync,
  input wire logic dn_data,
  input wire logic up_dev_oe
);
  logic fs_q_ff;
  logic arm_ff;
  logic [12:0] fr_cnt_ff;
  logic [9:0] oe_run_ff;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // Frame length and drive window counters; arm skips the first frame
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fs_q_ff <= 1'h0;
      arm_ff <= 1'h0;
      fr_cnt_ff <= 13'h0000;
      oe_run_ff <= 10'h000;
    end
    else
    begin
      fs_q_ff <= fsync;
      arm_ff <= arm_ff | (fsync & ~fs_q_ff);
      fr_cnt_ff <= (fsync & ~fs_q_ff) ? 13'h0001 : fr_cnt_ff + 13'h0001;
      oe_run_ff <= up_dev_oe ? oe_run_ff + 10'h001 : 10'h000;
    end
  end

  AST_HALF_PERIOD: assert property (
    $changed(highway_bit_clock) |=> $stable(highway_bit_clock)[*3]
    ##1 $changed(highway_bit_clock)) else $error("bit clock half period");
  AST_FSYNC_WIDTH: assert property (
    $rose(fsync) |-> fsync[*8] ##1 !fsync) else $error("frame sync width");
  AST_FSYNC_EDGE: assert property (
    $rose(fsync) |-> $fell(highway_bit_clock)) else $error("sync edge");
  AST_DN_EDGE: assert property (
    $changed(dn_data) |-> $fell(highway_bit_clock))
    else $error("down data moved off falling clock");
  AST_FRAME_LEN: assert property (
    $rose(fsync) && arm_ff |-> fr_cnt_ff == 13'h1000)
    else $error("frame length");
  AST_OE_WINDOW: assert property (
    $fell(up_dev_oe) |-> oe_run_ff == 10'h200) else $error("slot width");
  AST_OE_MAX: assert property (
    up_dev_oe |-> oe_run_ff < 10'h200) else $error("drive too long");
  AST_IDLE_RELEASE: assert property (
    $rose(resetn_i) |-> dn_data && !up_dev_oe && !fsync)
    else $error("highway not idle after reset");
endmodule
`default_nettype wire

// *** test/tb_tdm_slot_command_port.sv ***
// Bench: controller and codec front end joined over the highway
`default_nettype none
module tb_tdm_slot_command_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ADR = 8'h3b; // Arbitrary value
  localparam logic [15:0] IDC = 16'h6d27; // Arbitrary value
  localparam logic [1:0] Z = tsc_pkg::STRAP_ZERO;
  localparam logic [1:0] P = tsc_pkg::STRAP_P;
  localparam logic [1:0] N = tsc_pkg::STRAP_N;
  localparam logic [1:0] SA [8] = '{Z, Z, P, P, Z, N, P, N};
  localparam logic [1:0] SB [8] = '{Z, N, Z, N, P, Z, P, P};
  logic clk_sys_i;
  logic resetn_i;
  logic [1:0] addr, sa, sb;
  logic [7:0] wdata, rdata, b, cfg;
  logic wr, rd;
  logic [15:0] voice_tx, voice_rx;
  logic [5:0] ci_tx, ci_rx;
  logic [2:0] slot;
  logic [31:0] word;
  int miscompares = 0;
  int check_count = 0;

  tsc_hwy_if tsc_hwy_if_i ();
  tsc_dev #(.DEV_ADDR(ADR), .DEV_ID(IDC), .LEGACY_REV(1'h1)) tsc_dev_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hwy(tsc_hwy_if_i),
    .slot_strap_a_i(sa), .slot_strap_b_i(sb), .voice_tx_i(voice_tx),
    .ci_tx_i(ci_tx), .voice_rx_o(voice_rx), .ci_rx_o(ci_rx),
    .first_config_register_o(cfg), .slot_o(slot));
  tsc_ctl tsc_ctl_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .hwy(tsc_hwy_if_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata));
  tsc_hwy_assertions tsc_hwy_assertions_i (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .highway_bit_clock(tsc_hwy_if_i.highway_bit_clock),
    .fsync(tsc_hwy_if_i.fsync), .dn_data(tsc_hwy_if_i.dn_data),
    .up_dev_oe(tsc_hwy_if_i.up_dev_oe));

  // 40 MHz system clock
  initial
  begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Register port: one-cycle strobes, read data stands the next cycle
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_sys_i);
    wr <= 1'h0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys_i);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  // A write while busy is dropped, so poll the busy flag first
  task automatic send(input logic [7:0] d);
    logic [7:0] st;
    st = 8'hff;
    for (int n = 0; n < 30000 && st[tsc_pkg::STAT_BUSY] !== 1'h0; n++)
      reg_rd(tsc_pkg::REG_STAT, st);
    reg_wr(tsc_pkg::REG_TX, d);
  endtask

  task automatic recv(output logic [7:0] d);
    logic [7:0] st;
    st = 8'h00;
    for (int n = 0; n < 30000 && st[tsc_pkg::STAT_RXV] !== 1'h1; n++)
      reg_rd(tsc_pkg::REG_STAT, st);
    reg_rd(tsc_pkg::REG_RX, d);
  endtask

  // Cuts a hang short; bytes take several frames each
  initial
  begin
    repeat (600000) @(posedge clk_sys_i);
    miscompares++;
    finish_test();
  end

  initial
  begin
    resetn_i = 1'h0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    sa = Z;
    sb = Z;
    voice_tx = 16'hc35a;
    ci_tx = 6'h2d;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    reg_rd(tsc_pkg::REG_CHAN, b);
    chk(b, tsc_pkg::CHAN_RST);
    chk(cfg, tsc_pkg::CFG_RST);
    // All eight channel strap codes, one frame each since the slot is taken at sync
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys_i);
      sa <= SA[k];
      sb <= SB[k];
      @(posedge tsc_hwy_if_i.fsync);
      repeat (16) @(posedge clk_sys_i);
      chk(slot, k);
    end
    @(posedge clk_sys_i);
    sa <= P;
    sb <= N;
    reg_wr(tsc_pkg::REG_CHAN, 8'h03);
    // New straps act from the next frame; sample mid-bit, MSB first
    @(posedge tsc_hwy_if_i.fsync);
    @(posedge tsc_hwy_if_i.up_dev_oe);
    repeat (8) @(posedge clk_sys_i);
    for (int i = 31; i >= 0; i--)
    begin
      word[i] = tsc_hwy_if_i.up_data;
      repeat (16) @(posedge clk_sys_i);
    end
    chk(word[31:16], voice_tx);
    chk(word[7:2], ci_tx);
    // Idle-high byte seen in other channels is still acknowledged
    chk(word[1:0], 2'h2);
    chk(voice_rx, 16'h0000);
    chk(ci_rx, 6'h3f);
    // Released upstream line read as all ones while the slot was elsewhere
    reg_rd(tsc_pkg::REG_RX, b);
    chk(b, 8'hff);
    send(tsc_pkg::ID_REQ0);
    send(tsc_pkg::ID_REQ1);
    recv(b);
    chk(b, IDC[15:8]);
    recv(b);
    chk(b, IDC[7:0]);
    chk(slot, 3'h3);
    // Stray read command without address must draw no reply
    send(8'h04);
    send(ADR);
    send(8'h00);
    send(8'ha5);
    // Second write lands in the blocked window and must have no effect
    send(ADR);
    send(8'h00);
    send(8'h3c);
    // Read right after the write, as the old revision needs
    send(ADR);
    send(8'h04);
    recv(b);
    chk(b, ADR);
    recv(b);
    chk(b, 8'ha5);
    chk(cfg, 8'ha5);
    reg_rd(tsc_pkg::REG_STAT, b);
    chk(b[tsc_pkg::STAT_RXV], 1'h0);
    finish_test();
  end
endmodule
`default_nettype wire
